// ===== dv/rxfe_adc_model.sv
`timescale 1ns/1ps
// converter-side stand-in: bursts of random symbols with gaps, on the falling edge
module rxfe_adc_model (
   input wire logic i_clock, // symbol-rate clock
   input wire logic i_start, // pulse: begin a burst
   input wire logic [15:0] i_count, // samples in the burst
   input wire logic i_ovf_all, // flag overflow on every sample
   output logic o_valid, // sample strobe
   output logic [15:0] o_sample, // converter word
   output logic o_overflow, // overflow flag
   output logic [15:0] o_far // echo-cancelled word
);
   integer seed = 32'h3afb;
   int left = 0;
   initial begin
      o_valid = 1'b0;
      o_sample = 16'h0000;
      o_overflow = 1'b0;
      o_far = 16'h0000;
   end
   // off-strobe lines flip every cycle so stale data never looks fresh
   always @(negedge i_clock) begin
      if (i_start) left = i_count;
      if (left > 0 && ($random(seed) & 3) != 0) begin
         o_valid <= 1'b1; // one 16-bit word per symbol strobe
         o_sample <= 16'($random(seed) % 8192);
         o_far <= 16'($random(seed) % 8192);
         o_overflow <= i_ovf_all | 1'($random(seed));
         left = left - 1;
      end else begin
         o_valid <= 1'b0;
         o_sample <= ~o_sample;
         o_far <= ~o_far;
         o_overflow <= ~o_overflow;
      end
   end
endmodule

// ===== dv/tb_rxfe_front_end.sv
`timescale 1ns/1ps
module tb_rxfe_front_end;
   import rxfe_pkg::*;
   // pval starts low: the first reset is already low at time zero, so no edge clears the model then
   logic i_clock = 1'b0, i_rst_b = 1'b0, i_wr = 1'b0, i_rd = 1'b0, start = 1'b0, ovf_all = 1'b0, pval = 1'b0;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, e_ov, ocnt, e_cause, mask;
   logic [15:0] cnt = 16'h0000, off, ivl, hi, lo, e_dc, e_sl, e_fe, pcorr, c;
   logic [19:0] a_dc, a_sl, a_fe;
   wire logic sv, ov, o_corrected_valid, o_irq;
   wire logic [15:0] smp, far, o_corrected_sample;
   wire logic [7:0] o_rdata;
   wire logic [2:0] o_vga_gain;
   logic [7:0] regs [17] = '{8'h03, 8'h18, 8'h19, 8'h21, 8'h26, 8'h27, 8'h30, 8'h31, 8'h32, 8'h33,
                             8'h05, 8'h42, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48};
   int mismatches = 0, tests_run = 0, cycles = 0, nsamp, tmr, i;
   integer seed = 32'h3afb;
   always #12.5 i_clock = ~i_clock;
   // accumulators narrowed to 20 bits so the top 16 carry real signal
   rxfe_front_end #(.ACC_W(20)) rxfe_front_end_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_sample_valid(sv),
      .i_adc_sample(smp), .i_adc_overflow(ov), .i_far_end_sample(far), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_vga_gain(o_vga_gain), .o_corrected_valid(o_corrected_valid),
      .o_corrected_sample(o_corrected_sample), .o_irq(o_irq));
   rxfe_adc_model rxfe_adc_model_i (.i_clock(i_clock), .i_start(start), .i_count(cnt), .i_ovf_all(ovf_all),
      .o_valid(sv), .o_sample(smp), .o_overflow(ov), .o_far(far));
   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   function automatic logic [15:0] sat(logic [15:0] s);
      int d;
      d = int'($signed(s)) - int'($signed(off));
      return (d > 32767) ? 16'h7fff : (d < -32768) ? 16'h8000 : 16'(d);
   endfunction
   function automatic logic [19:0] mag(logic [15:0] v);
      return 20'(v[15] ? -int'($signed(v)) : int'($signed(v)));
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("counts: %0d checks, %0d mismatches", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // register writes also steer the reference model, taken once the design has them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clock);
      i_wr = 1'b1;
      i_addr = a;
      i_wdata = d;
      @(negedge i_clock);
      i_wr = 1'b0;
      case (a)
         8'h03: mask = d;
         8'h05: e_cause = e_cause & ~d;
         8'h18: ivl[7:0] = d;
         8'h19: ivl[15:8] = d;
         8'h26: off[7:0] = d;
         8'h27: off[15:8] = d;
         8'h30: hi[7:0] = d;
         8'h31: hi[15:8] = d;
         8'h32: lo[7:0] = d;
         8'h33: lo[15:8] = d;
         default: ;
      endcase
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge i_clock);
      i_rd = 1'b1;
      i_addr = a;
      @(negedge i_clock);
      i_rd = 1'b0;
      chk(o_rdata, exp);
   endtask
   task automatic rst;
      i_rst_b = 1'b0;
      repeat (10) @(negedge i_clock);
      {off, ivl, hi, lo, mask} = '0;
      i_rst_b = 1'b1;
   endtask
   task automatic burst(input int n, input logic all);
      int t;
      t = nsamp + n;
      ovf_all <= all;
      cnt <= 16'(n);
      start <= 1'b1;
      @(negedge i_clock);
      start <= 1'b0;
      for (int k = 0; k < 8 * n + 20 && nsamp < t; k++) @(negedge i_clock);
      repeat (4) @(negedge i_clock);
   endtask
   task automatic meters;
      rchk(8'h42, e_ov); // saturating overflow count per interval
      rchk(8'h44, e_dc[7:0]); // dc sum, top bits
      rchk(8'h45, e_dc[15:8]); // dc sum, top bits
      rchk(8'h46, e_sl[7:0]); // signal level
      rchk(8'h47, e_sl[15:8]); // signal level
      rchk(8'h48, e_fe[7:0]); // far-end level
      rchk(8'h49, e_fe[15:8]); // far-end level
      rchk(8'h05, e_cause); // alarm causes
      chk(o_irq, |e_cause); // pending unmasked alarm
   endtask
   // ----------------------------------------------------------
   // reference model: one step per accepted symbol
   // ----------------------------------------------------------
   always @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pval <= 1'b0;
         {nsamp, tmr} = '0;
         {a_dc, a_sl, a_fe, e_dc, e_sl, e_fe, e_ov, ocnt, e_cause} = '0;
      end else begin
         pval <= sv;
         if (sv) begin
            c = sat(smp);
            pcorr <= c;
            nsamp++;
            a_dc = a_dc + 20'($signed(c));
            a_sl = a_sl + mag(c);
            a_fe = a_fe + mag(far);
            if (ov && ocnt != 8'hff) ocnt++;
            if (tmr == 0) begin
               {e_dc, e_sl, e_fe, e_ov} = {a_dc[19:4], a_sl[19:4], a_fe[19:4], ocnt};
               if (e_fe > hi && !mask[2]) e_cause[2] = 1'b1;
               if (e_fe < lo && !mask[1]) e_cause[1] = 1'b1;
               {a_dc, a_sl, a_fe, ocnt} = '0;
               tmr = ivl;
            end else tmr--;
         end
      end
   end
   // corrected stream checked every cycle out of reset; the hang guard lives here too
   always @(negedge i_clock) begin
      cycles++;
      if (cycles > 20000) begin
         mismatches++;
         give_verdict;
      end
      if (i_rst_b) begin
         chk(o_corrected_valid, pval); // one result per symbol, one cycle later
         if (pval) chk(o_corrected_sample, pcorr); // offset subtracted, saturated
      end
   end
   initial begin
      rst;
      for (i = 0; i < 17; i++) rchk(regs[i], 8'h00); // every register except 8'h49 reads clear after reset
      rchk(8'h50, 8'h00); // unmapped place reads zero
      $display("done: reset values");
      for (i = 0; i < 8; i++) begin
         wr(8'h21, 8'(i));
         chk(o_vga_gain, 16'(i > 5 ? 5 : i)); // six gain codes, upper ones clamp
         rchk(8'h21, 8'(i)); // stored as written
      end
      for (i = 0; i < 10; i++) begin
         c = 16'($random(seed));
         wr(regs[i], c[7:0]);
         rchk(regs[i], c[7:0]); // read-write storage
      end
      wr(8'h42, 8'hff);
      rchk(8'h42, 8'h00); // result register ignores writes
      $display("done: register access");
      rst;
      wr(8'h18, 8'h07);
      wr(8'h26, 8'($random(seed)));
      wr(8'h30, 8'h10);
      wr(8'h33, 8'hff);
      burst(25, 1'b0);
      meters;
      wr(8'h05, 8'h06);
      rchk(8'h05, 8'h00); // causes clear on write of ones
      chk(o_irq, 1'b0); // request drops once cleared
      $display("done: meters and alarms");
      rst;
      wr(8'h03, 8'h06); // mask both far-end alarms
      wr(8'h32, 8'hff);
      wr(8'h33, 8'hff);
      burst(9, 1'b0);
      meters;
      $display("done: masked alarms");
      rst;
      wr(8'h18, 8'h2b);
      wr(8'h19, 8'h01);
      burst(301, 1'b1);
      meters;
      $display("done: overflow saturation");
      rst;
      wr(8'h26, 8'hff);
      wr(8'h27, 8'h7f);
      burst(10, 1'b0);
      $display("done: offset saturation");
      give_verdict;
   end
endmodule

// ===== verilog/rxfe_clip_cnt.sv
`timescale 1ns/1ps
// saturating overflow counter, dumped on interval close
module rxfe_clip_cnt
   import rxfe_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input wire logic i_clock, // symbol-rate clock
   input wire logic i_rst_b, // async reset, active low
   input wire logic i_event, // converter overflow this symbol
   input wire logic i_close, // last sample of the interval
   output logic [CNT_W-1:0] o_result // count of last interval
);
   initial begin
      if (CNT_W < 1) $error("rxfe_clip_cnt: bad width");
   end

   localparam logic [CNT_W-1:0] CNT_MAX = '1;

   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [CNT_W-1:0] res_q, res_d;
   logic [CNT_W-1:0] bumped;

   // ------------------------------------------------------------
   // count with hold at full scale
   // ------------------------------------------------------------
   always_comb begin
      bumped = (i_event && cnt_q != CNT_MAX) ? cnt_q + 1'b1 : cnt_q;
      cnt_d = bumped;
      res_d = res_q;
      if (i_close) begin
         res_d = bumped;
         cnt_d = '0;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= '0;
         res_q <= '0;
      end else begin
         cnt_q <= cnt_d;
         res_q <= res_d;
      end
   end

   assign o_result = res_q;

   property p_clip_hold;
      @(posedge i_clock) disable iff (!i_rst_b) (cnt_q == CNT_MAX && !i_close) |=> cnt_q == CNT_MAX;
   endproperty
   a_clip_hold: assert property (p_clip_hold) else $error("overflow count left full scale");

   property p_clip_count;
      @(posedge i_clock) disable iff (!i_rst_b)
         (i_event && !i_close && cnt_q < CNT_MAX) |=> cnt_q == $past(cnt_q) + 1'b1;
   endproperty
   a_clip_count: assert property (p_clip_count) else $error("overflow not counted");
endmodule

// ===== verilog/rxfe_front_end.sv
`timescale 1ns/1ps
module rxfe_front_end
   import rxfe_pkg::*;
#(
   parameter int ACC_W = RXFE_ACC_W
) (
   input wire logic i_clock, // symbol-rate clock, 40 MHz
   input wire logic i_rst_b, // async reset, active low
   input wire logic i_sample_valid, // one symbol strobe
   input wire logic [15:0] i_adc_sample, // converter word, two's complement
   input wire logic i_adc_overflow, // converter overflow flag for this sample
   input wire logic [15:0] i_far_end_sample, // echo-cancelled sample, same strobe
   input wire logic [7:0] i_addr, // register address
   input wire logic [7:0] i_wdata, // register write data
   input wire logic i_wr, // write strobe, one cycle
   input wire logic i_rd, // read strobe, one cycle
   output logic [7:0] o_rdata, // read data, valid cycle after i_rd
   output logic [2:0] o_vga_gain, // amplifier gain select
   output logic o_corrected_valid, // corrected sample strobe
   output logic [15:0] o_corrected_sample, // offset-corrected sample
   output logic o_irq // unmasked alarm pending, active high
);
   initial begin
      if (ACC_W < RXFE_SAMPLE_W + 1 || ACC_W > 48) $error("rxfe_front_end: ACC_W out of range");
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   logic [7:0] mask_q, mask_d;
   logic [7:0] int_lsb_q, int_lsb_d;
   logic [7:0] int_msb_q, int_msb_d;
   logic [7:0] gain_q, gain_d;
   logic [15:0] offset_q, offset_d;
   logic [15:0] upper_q, upper_d;
   logic [15:0] lower_q, lower_d;

   // byte-wide writes land one edge after the strobe
   always_comb begin
      mask_d = mask_q;
      int_lsb_d = int_lsb_q;
      int_msb_d = int_msb_q;
      gain_d = gain_q;
      offset_d = offset_q;
      upper_d = upper_q;
      lower_d = lower_q;
      if (i_wr) begin
         unique case (i_addr)
            RXFE_OFF_IRQ_MASK_UPPER: mask_d = i_wdata;
            RXFE_OFF_INTERVAL_LSB: int_lsb_d = i_wdata;
            RXFE_OFF_INTERVAL_MSB: int_msb_d = i_wdata;
            RXFE_OFF_GAIN_CTRL: gain_d = i_wdata;
            RXFE_OFF_OFFSET_LSB: offset_d[7:0] = i_wdata;
            RXFE_OFF_OFFSET_MSB: offset_d[15:8] = i_wdata;
            RXFE_OFF_UPPER_LIMIT_LSB: upper_d[7:0] = i_wdata;
            RXFE_OFF_UPPER_LIMIT_MSB: upper_d[15:8] = i_wdata;
            RXFE_OFF_LOWER_LIMIT_LSB: lower_d[7:0] = i_wdata;
            RXFE_OFF_LOWER_LIMIT_MSB: lower_d[15:8] = i_wdata;
            default: ; // read-only or unmapped: write ignored
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         mask_q <= RXFE_RST_BYTE;
         int_lsb_q <= RXFE_RST_BYTE;
         int_msb_q <= RXFE_RST_BYTE;
         gain_q <= RXFE_RST_BYTE;
         offset_q <= RXFE_RST_WORD;
         upper_q <= RXFE_RST_WORD;
         lower_q <= RXFE_RST_WORD;
      end else begin
         mask_q <= mask_d;
         int_lsb_q <= int_lsb_d;
         int_msb_q <= int_msb_d;
         gain_q <= gain_d;
         offset_q <= offset_d;
         upper_q <= upper_d;
         lower_q <= lower_d;
      end
   end

   // ------------------------------------------------------------
   // gain select
   // ------------------------------------------------------------
   logic [2:0] gain_field;

   // codes 6 and 7 have no amplifier setting, so they clamp to the top one
   always_comb begin
      gain_field = gain_q[RXFE_GAIN_LSB +: RXFE_GAIN_W];
      o_vga_gain = (gain_field > RXFE_GAIN_MAX) ? RXFE_GAIN_MAX : gain_field;
   end

   // ------------------------------------------------------------
   // offset correction
   // ------------------------------------------------------------
   logic [16:0] diff;
   logic [15:0] corr_q, corr_d;
   logic corr_vld_q, corr_vld_d;
   logic ovf_q, ovf_d;
   logic [15:0] far_q, far_d;

   // saturate rather than wrap: a wrapped sample would wreck the meters
   always_comb begin
      diff = {i_adc_sample[15], i_adc_sample} - {offset_q[15], offset_q};
      corr_d = corr_q;
      far_d = far_q;
      ovf_d = 1'b0;
      corr_vld_d = i_sample_valid;
      if (i_sample_valid) begin
         far_d = i_far_end_sample;
         ovf_d = i_adc_overflow;
         if (diff[16] != diff[15]) begin
            corr_d = diff[16] ? 16'h8000 : 16'h7fff;
         end else begin
            corr_d = diff[15:0];
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         corr_q <= RXFE_RST_WORD;
         far_q <= RXFE_RST_WORD;
         corr_vld_q <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         corr_q <= corr_d;
         far_q <= far_d;
         corr_vld_q <= corr_vld_d;
         ovf_q <= ovf_d;
      end
   end

   assign o_corrected_sample = corr_q;
   assign o_corrected_valid = corr_vld_q;

   // ------------------------------------------------------------
   // shared interval timer, counted in symbols
   // ------------------------------------------------------------
   logic [15:0] tmr_q, tmr_d;
   logic close;
   logic fresh_q, fresh_d;

   // interval is the programmed value plus one symbols
   always_comb begin
      close = corr_vld_q && (tmr_q == 16'h0000);
      tmr_d = tmr_q;
      if (corr_vld_q) begin
         tmr_d = close ? {int_msb_q, int_lsb_q} : tmr_q - 16'h0001;
      end
      fresh_d = close; // results are new in the cycle after close
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tmr_q <= RXFE_RST_WORD;
         fresh_q <= 1'b0;
      end else begin
         tmr_q <= tmr_d;
         fresh_q <= fresh_d;
      end
   end

   // ------------------------------------------------------------
   // meters, all closed by the same strobe
   // ------------------------------------------------------------
   logic [15:0] dc_res;
   logic [15:0] input_res;
   logic [15:0] remote_res;
   logic [7:0] clip_res;

   rxfe_level_acc #(.IN_W(16), .ACC_W(ACC_W), .RES_W(16), .USE_ABS(1'b0)) u_dc_meter (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_valid(corr_vld_q),
      .i_sample(corr_q),
      .i_close(close),
      .o_result(dc_res)
   );

   rxfe_level_acc #(.IN_W(16), .ACC_W(ACC_W), .RES_W(16), .USE_ABS(1'b1)) u_input_meter (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_valid(corr_vld_q),
      .i_sample(corr_q),
      .i_close(close),
      .o_result(input_res)
   );

   rxfe_level_acc #(.IN_W(16), .ACC_W(ACC_W), .RES_W(16), .USE_ABS(1'b1)) u_remote_meter (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_valid(corr_vld_q),
      .i_sample(far_q),
      .i_close(close),
      .o_result(remote_res)
   );

   rxfe_clip_cnt #(.CNT_W(RXFE_CLIP_W)) u_clip (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_event(corr_vld_q && ovf_q),
      .i_close(close),
      .o_result(clip_res)
   );

   // ------------------------------------------------------------
   // far-end alarms
   // ------------------------------------------------------------
   logic above_hi;
   logic below_lo;
   logic [7:0] cause_q, cause_d;
   logic hi_set;
   logic lo_set;

   // checked once per fresh result; set beats a same-cycle clear
   always_comb begin
      above_hi = remote_res > upper_q;
      below_lo = remote_res < lower_q;
      hi_set = fresh_q && above_hi && !mask_q[RXFE_BIT_HIGH_ALARM];
      lo_set = fresh_q && below_lo && !mask_q[RXFE_BIT_LOW_ALARM];
      cause_d = cause_q;
      if (i_wr && i_addr == RXFE_OFF_INTERRUPT_CAUSE) begin
         cause_d = cause_q & ~i_wdata; // write one to clear
      end
      if (hi_set) begin
         cause_d[RXFE_BIT_HIGH_ALARM] = 1'b1;
      end
      if (lo_set) begin
         cause_d[RXFE_BIT_LOW_ALARM] = 1'b1;
      end
      cause_d = cause_d & ((8'h01 << RXFE_BIT_HIGH_ALARM) | (8'h01 << RXFE_BIT_LOW_ALARM));
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cause_q <= RXFE_RST_BYTE;
      end else begin
         cause_q <= cause_d;
      end
   end

   assign o_irq = |(cause_q & ~mask_q);

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   logic [7:0] rdata_q, rdata_d;

   // unmapped addresses read zero
   always_comb begin
      rdata_d = rdata_q;
      if (i_rd) begin
         unique case (i_addr)
            RXFE_OFF_IRQ_MASK_UPPER: rdata_d = mask_q;
            RXFE_OFF_INTERRUPT_CAUSE: rdata_d = cause_q;
            RXFE_OFF_INTERVAL_LSB: rdata_d = int_lsb_q;
            RXFE_OFF_INTERVAL_MSB: rdata_d = int_msb_q;
            RXFE_OFF_GAIN_CTRL: rdata_d = gain_q;
            RXFE_OFF_OFFSET_LSB: rdata_d = offset_q[7:0];
            RXFE_OFF_OFFSET_MSB: rdata_d = offset_q[15:8];
            RXFE_OFF_UPPER_LIMIT_LSB: rdata_d = upper_q[7:0];
            RXFE_OFF_UPPER_LIMIT_MSB: rdata_d = upper_q[15:8];
            RXFE_OFF_LOWER_LIMIT_LSB: rdata_d = lower_q[7:0];
            RXFE_OFF_LOWER_LIMIT_MSB: rdata_d = lower_q[15:8];
            RXFE_OFF_CLIP_RESULT: rdata_d = clip_res;
            RXFE_OFF_DC_RESULT_LSB: rdata_d = dc_res[7:0];
            RXFE_OFF_DC_RESULT_MSB: rdata_d = dc_res[15:8];
            RXFE_OFF_INPUT_RESULT_LSB: rdata_d = input_res[7:0];
            RXFE_OFF_INPUT_RESULT_MSB: rdata_d = input_res[15:8];
            RXFE_OFF_REMOTE_RESULT_LSB: rdata_d = remote_res[7:0];
            RXFE_OFF_REMOTE_RESULT_MSB: rdata_d = remote_res[15:8];
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rdata_q <= RXFE_RST_BYTE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign o_rdata = rdata_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_b);

   sequence s_sample_in;
      i_sample_valid && ($signed(i_adc_sample) - $signed(offset_q) <= 32767)
         && ($signed(i_adc_sample) - $signed(offset_q) >= -32768) && !i_wr;
   endsequence

   property p_offset;
      s_sample_in |=> o_corrected_valid && o_corrected_sample == $past(i_adc_sample) - $past(offset_q);
   endproperty
   a_offset: assert property (p_offset) else $error("offset not subtracted");

   property p_one_per_symbol;
      !i_sample_valid |=> !o_corrected_valid;
   endproperty
   a_one_per_symbol: assert property (p_one_per_symbol) else $error("sample without symbol strobe");

   property p_gain;
      (i_wr && i_addr == RXFE_OFF_GAIN_CTRL && i_wdata[2:0] <= RXFE_GAIN_MAX)
         |=> o_vga_gain == $past(i_wdata[2:0]) && o_vga_gain <= RXFE_GAIN_MAX;
   endproperty
   a_gain: assert property (p_gain) else $error("gain field not applied");

   property p_sync_update;
      ($changed(dc_res) || $changed(input_res) || $changed(remote_res) || $changed(clip_res)) |-> fresh_q;
   endproperty
   a_sync_update: assert property (p_sync_update) else $error("meter updated off the boundary");

   sequence s_close_hi;
      close ##1 (above_hi && !mask_q[RXFE_BIT_HIGH_ALARM]);
   endsequence

   property p_high_alarm;
      s_close_hi |=> cause_q[RXFE_BIT_HIGH_ALARM] && o_irq;
   endproperty
   a_high_alarm: assert property (p_high_alarm) else $error("high alarm missed");

   sequence s_close_lo;
      close ##1 (below_lo && !mask_q[RXFE_BIT_LOW_ALARM]);
   endsequence

   property p_low_alarm;
      s_close_lo |=> cause_q[RXFE_BIT_LOW_ALARM] && o_irq;
   endproperty
   a_low_alarm: assert property (p_low_alarm) else $error("low alarm missed");

   property p_no_false_high;
      $rose(cause_q[RXFE_BIT_HIGH_ALARM]) |-> $past(fresh_q && above_hi);
   endproperty
   a_no_false_high: assert property (p_no_false_high) else $error("high alarm without cause");

   property p_no_false_low;
      $rose(cause_q[RXFE_BIT_LOW_ALARM]) |-> $past(fresh_q && below_lo);
   endproperty
   a_no_false_low: assert property (p_no_false_low) else $error("low alarm without cause");

   property p_read_remote;
      (i_rd && i_addr == RXFE_OFF_REMOTE_RESULT_MSB) |=> o_rdata == $past(remote_res[15:8]);
   endproperty
   a_read_remote: assert property (p_read_remote) else $error("far-end result misread");
endmodule

// ===== verilog/rxfe_level_acc.sv
`timescale 1ns/1ps
// one meter: sums a sample term per symbol, dumps top bits on interval close
module rxfe_level_acc
   import rxfe_pkg::*;
#(
   parameter int IN_W = 16,
   parameter int ACC_W = 32,
   parameter int RES_W = 16,
   parameter bit USE_ABS = 1'b0
) (
   input wire logic i_clock, // symbol-rate clock
   input wire logic i_rst_b, // async reset, active low
   input wire logic i_valid, // one sample this cycle
   input wire logic signed [IN_W-1:0] i_sample, // sample to measure
   input wire logic i_close, // last sample of the interval
   output logic [RES_W-1:0] o_result // top bits of last interval
);
   initial begin
      if (ACC_W < IN_W + 1 || RES_W > ACC_W) $error("rxfe_level_acc: bad widths");
   end

   logic signed [ACC_W-1:0] acc_q, acc_d;
   logic [RES_W-1:0] res_q, res_d;
   logic signed [ACC_W-1:0] term;
   logic signed [ACC_W-1:0] sum;

   // ------------------------------------------------------------
   // accumulate, restart at each interval close
   // ------------------------------------------------------------
   always_comb begin
      term = ACC_W'(i_sample);
      if (USE_ABS && i_sample[IN_W-1]) begin
         term = -term; // full-scale negative still fits, acc is wider
      end
      sum = acc_q + (i_valid ? term : '0);
      acc_d = sum;
      res_d = res_q;
      if (i_close) begin
         res_d = sum[ACC_W-1 -: RES_W];
         acc_d = '0;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         acc_q <= '0;
         res_q <= '0;
      end else begin
         acc_q <= acc_d;
         res_q <= res_d;
      end
   end

   assign o_result = res_q;

   property p_acc_restart;
      @(posedge i_clock) disable iff (!i_rst_b) i_close |=> acc_q == 0;
   endproperty
   a_acc_restart: assert property (p_acc_restart) else $error("meter did not restart");
endmodule

// ===== verilog/rxfe_pkg.sv
package rxfe_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] RXFE_OFF_IRQ_MASK_UPPER = 8'h03;
   localparam logic [7:0] RXFE_OFF_INTERRUPT_CAUSE = 8'h05;
   localparam logic [7:0] RXFE_OFF_INTERVAL_LSB = 8'h18;
   localparam logic [7:0] RXFE_OFF_INTERVAL_MSB = 8'h19;
   localparam logic [7:0] RXFE_OFF_GAIN_CTRL = 8'h21;
   localparam logic [7:0] RXFE_OFF_OFFSET_LSB = 8'h26;
   localparam logic [7:0] RXFE_OFF_OFFSET_MSB = 8'h27;
   localparam logic [7:0] RXFE_OFF_UPPER_LIMIT_LSB = 8'h30;
   localparam logic [7:0] RXFE_OFF_UPPER_LIMIT_MSB = 8'h31;
   localparam logic [7:0] RXFE_OFF_LOWER_LIMIT_LSB = 8'h32;
   localparam logic [7:0] RXFE_OFF_LOWER_LIMIT_MSB = 8'h33;
   localparam logic [7:0] RXFE_OFF_CLIP_RESULT = 8'h42;
   localparam logic [7:0] RXFE_OFF_DC_RESULT_LSB = 8'h44;
   localparam logic [7:0] RXFE_OFF_DC_RESULT_MSB = 8'h45;
   localparam logic [7:0] RXFE_OFF_INPUT_RESULT_LSB = 8'h46;
   localparam logic [7:0] RXFE_OFF_INPUT_RESULT_MSB = 8'h47;
   localparam logic [7:0] RXFE_OFF_REMOTE_RESULT_LSB = 8'h48;
   localparam logic [7:0] RXFE_OFF_REMOTE_RESULT_MSB = 8'h49;

   // ------------------------------------------------------------
   // field positions and limits
   // ------------------------------------------------------------
   localparam int RXFE_BIT_HIGH_ALARM = 2;
   localparam int RXFE_BIT_LOW_ALARM = 1;
   localparam int RXFE_GAIN_LSB = 0;
   localparam int RXFE_GAIN_W = 3;
   localparam logic [2:0] RXFE_GAIN_MAX = 3'h5;
   localparam int RXFE_SAMPLE_W = 16;
   localparam int RXFE_RESULT_W = 16;
   localparam int RXFE_CLIP_W = 8;
   localparam int RXFE_ACC_W = 32;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RXFE_RST_BYTE = 8'h00;
   localparam logic [15:0] RXFE_RST_WORD = 16'h0000;
endpackage
